// ### hw/pe_gpio_top.v
// Port E general-purpose I/O with LCD and channel 2 pin sharing.
`timescale 1ns/100ps
`include "pe_gpio_consts.vh"

module pe_gpio_top #(
	parameter NUM_COMMONS = 4
) (
	// Clock and reset.
	input  wire       REF_CLK_I,
	input  wire       RST_N_I,
	// Register port.
	input  wire [2:0] REG_ADDR_I,
	input  wire [7:0] REG_WDATA_I,
	input  wire       REG_WR_I,
	input  wire       REG_RD_I,
	output reg  [7:0] REG_RDATA_O,
	// Pads.
	input  wire [7:0] PIN_IN_I,
	output reg  [7:0] PIN_OUT_O,
	output reg  [7:0] PIN_OE_O,
	output reg  [7:0] PULLUP_EN_O,
	// Configuration fuse, low maps channel 2 to pin 7.
	input  wire       CHAN2_PIN_MAP_FUSE_I,
	// Capture/compare/PWM channel 2.
	input  wire       CHAN2_CMP_ACTIVE_I,
	input  wire       CHAN2_CMP_OUT_I,
	output reg        CHAN2_CAPTURE_O,
	// LCD pin hand-over.
	output reg  [3:0] LCD_COM_SEL_O,
	output reg        LCD_LCD_SEGMENT_31_SEL_O,
	output reg        LCD_BIAS_SEL_O
);

	// Register state.
	reg  [7:0] out_latch_q;
	reg  [7:0] direction_q;
	reg        pullup_dis_q;
	reg        chan2_od_q;
	reg        lcd_en_q;
	reg  [1:0] mux_q;
	reg        lcd_segment_31_q;

	// Synchronised pad and fuse levels.
	wire [7:0] pin_sync;
	wire       fuse_sync;

	// Pin ownership terms.
	reg  [7:0] com_mask;
	reg  [7:0] bias_mask;
	reg  [7:0] lcd_mask;
	reg        chan2_mapped;
	reg        chan2_drive;
	reg        chan2_listen;
	reg  [7:0] out_d;
	reg  [7:0] oe_d;
	reg  [7:0] pu_d;
	reg  [7:0] rdata_d;

	// True for a strobe aimed at one register index.
	function reg_hit;
		input       strobe;
		input [2:0] addr;
		input [2:0] idx;
		begin
			reg_hit = strobe && (addr == idx);
		end
	endfunction

	// Clears the bit positions that have no pin behind them.
	function [7:0] impl_only;
		input [7:0] bits;
		begin
			impl_only = bits & `PE_IMPL_MASK;
		end
	endfunction

	// Keeps the requested pins that the LCD does not own.
	function [7:0] free_pins;
		input [7:0] bits;
		input [7:0] owned;
		begin
			free_pins = impl_only(bits & ~owned);
		end
	endfunction

	// Write decode.
	wire wr_pin_levels = reg_hit(REG_WR_I, REG_ADDR_I, `PE_OFF_PIN_LEVELS);
	wire wr_out_latch  = reg_hit(REG_WR_I, REG_ADDR_I, `PE_OFF_OUT_LATCH);
	wire wr_direction  = reg_hit(REG_WR_I, REG_ADDR_I, `PE_OFF_DIRECTION);
	wire wr_pins_g     = reg_hit(REG_WR_I, REG_ADDR_I, `PE_OFF_PINS_G_PU);
	wire wr_dir_g      = reg_hit(REG_WR_I, REG_ADDR_I, `PE_OFF_DIR_G_OD);
	wire wr_lcd_ctl    = reg_hit(REG_WR_I, REG_ADDR_I, `PE_OFF_LCD_CONTROL);
	wire wr_seg_en3    = reg_hit(REG_WR_I, REG_ADDR_I, `PE_OFF_LCD_SEG_EN3);

	// Returns the pins taken by active commons for a multiplex setting.
	function [7:0] common_pins;
		input       en;
		input [1:0] mux;
		reg   [3:0] coms;
		begin
			coms = 4'h0;
			case (mux)
				2'h0: coms = 4'h1;
				2'h1: coms = 4'h3;
				2'h2: coms = 4'h7;
				2'h3: coms = 4'hF;
				default: coms = 4'h0;
			endcase
			if (!en) begin
				coms = 4'h0;
			end
			common_pins = {1'b0, coms, 3'b000};
		end
	endfunction

	// Pads and the fuse come from outside the clock domain.
	// The chains reset to zero; all pins are inputs then, so none is driven.
	pe_sync2 #(
		.WIDTH (8)
	) u_pin_sync (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.async_i (PIN_IN_I),
		.sync_o  (pin_sync)
	);

	pe_sync2 #(
		.WIDTH (1)
	) u_fuse_sync (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.async_i (CHAN2_PIN_MAP_FUSE_I),
		.sync_o  (fuse_sync)
	);

	// Output latch, written through either the port or the latch register.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			out_latch_q <= `PE_RST_LATCH;
		end else if (wr_pin_levels || wr_out_latch) begin
			out_latch_q <= impl_only(REG_WDATA_I);
		end
	end

	// Direction register; reset makes every pin an input.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			direction_q <= `PE_RST_DIRECTION;
		end else if (wr_direction) begin
			direction_q <= impl_only(REG_WDATA_I);
		end
	end

	// Shared pull-up disable, set by every reset.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pullup_dis_q <= `PE_RST_PULLUP_DIS;
		end else if (wr_pins_g) begin
			pullup_dis_q <= REG_WDATA_I[`PE_BIT_PULLUP_DIS];
		end
	end

	// Channel 2 open-drain select.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			chan2_od_q <= `PE_RST_CHAN2_OD;
		end else if (wr_dir_g) begin
			chan2_od_q <= REG_WDATA_I[`PE_BIT_CHAN2_OD];
		end
	end

	// LCD enable; it also hands pins 1 and 0 to the bias inputs.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			lcd_en_q <= `PE_RST_LCD_EN;
		end else if (wr_lcd_ctl) begin
			lcd_en_q <= REG_WDATA_I[`PE_BIT_LCD_EN];
		end
	end

	// Common multiplex field; it only matters while the LCD is enabled.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mux_q <= `PE_RST_MUX;
		end else if (wr_lcd_ctl) begin
			mux_q <= REG_WDATA_I[`PE_BIT_MUX_HI:`PE_BIT_MUX_LO];
		end
	end

	// Segment 31 enable.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			lcd_segment_31_q <= `PE_RST_LCD_SEGMENT_31;
		end else if (wr_seg_en3) begin
			lcd_segment_31_q <= REG_WDATA_I[`PE_BIT_LCD_SEGMENT_31];
		end
	end

	// Which pins the LCD and channel 2 take over.
	always @* begin
		com_mask  = common_pins(lcd_en_q, mux_q);
		bias_mask = 8'h00;
		if (lcd_en_q) begin
			bias_mask[`PE_BIT_BIAS_1] = 1'b1;
			bias_mask[`PE_BIT_BIAS_2] = 1'b1;
		end
		lcd_mask = com_mask | bias_mask;
		lcd_mask[`PE_BIT_LCD_SEGMENT_31] = lcd_segment_31_q;
		lcd_mask[`PE_BIT_UNUSED] = 1'b1;
		chan2_mapped = !fuse_sync;
		chan2_drive  = chan2_mapped && CHAN2_CMP_ACTIVE_I &&
			!direction_q[`PE_BIT_CHAN2_PIN] && !lcd_segment_31_q;
		chan2_listen = chan2_mapped && direction_q[`PE_BIT_CHAN2_PIN] &&
			!lcd_segment_31_q;
	end

	// Digital drive per pin.
	always @* begin
		out_d = 8'h00;
		oe_d  = 8'h00;
		out_d = free_pins(out_latch_q, lcd_mask);
		oe_d  = free_pins(~direction_q, lcd_mask);
		if (chan2_drive) begin
			out_d[`PE_BIT_CHAN2_PIN] = CHAN2_CMP_OUT_I;
			// Open drain only pulls low; a high level releases the pad.
			if (chan2_od_q) begin
				out_d[`PE_BIT_CHAN2_PIN] = 1'b0;
				oe_d[`PE_BIT_CHAN2_PIN]  = !CHAN2_CMP_OUT_I;
			end
		end
		// Commons are cleared last so no earlier term reopens them.
		oe_d = oe_d & ~com_mask;
	end

	// Weak pull-ups sit only on free input pins.
	always @* begin
		pu_d = 8'h00;
		if (!pullup_dis_q) begin
			pu_d = free_pins(direction_q, lcd_mask);
		end
	end

	// Registered pad drive.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PIN_OUT_O   <= 8'h00;
			PIN_OE_O    <= 8'h00;
			PULLUP_EN_O <= 8'h00;
		end else begin
			PIN_OUT_O   <= out_d;
			PIN_OE_O    <= oe_d;
			PULLUP_EN_O <= pu_d;
		end
	end

	// Registered LCD hand-over flags.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			LCD_COM_SEL_O   <= 4'h0;
			LCD_LCD_SEGMENT_31_SEL_O <= 1'b0;
			LCD_BIAS_SEL_O  <= 1'b0;
		end else begin
			LCD_COM_SEL_O   <= com_mask[`PE_BIT_COM_BASE +: 4];
			LCD_LCD_SEGMENT_31_SEL_O <= lcd_segment_31_q;
			LCD_BIAS_SEL_O  <= lcd_en_q;
		end
	end

	// Capture input follows pin 7 only while channel 2 listens on it.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CHAN2_CAPTURE_O <= 1'b0;
		end else if (chan2_listen) begin
			CHAN2_CAPTURE_O <= pin_sync[`PE_BIT_CHAN2_PIN];
		end else begin
			CHAN2_CAPTURE_O <= 1'b0;
		end
	end

	// Read multiplexer; unmapped addresses read zero.
	always @* begin
		rdata_d = 8'h00;
		case (REG_ADDR_I)
			`PE_OFF_PIN_LEVELS: begin
				rdata_d = impl_only(pin_sync);
			end
			`PE_OFF_OUT_LATCH: begin
				rdata_d = out_latch_q;
			end
			`PE_OFF_DIRECTION: begin
				rdata_d = direction_q;
			end
			`PE_OFF_PINS_G_PU: begin
				rdata_d[`PE_BIT_PULLUP_DIS] = pullup_dis_q;
			end
			`PE_OFF_DIR_G_OD: begin
				rdata_d[`PE_BIT_CHAN2_OD] = chan2_od_q;
			end
			`PE_OFF_LCD_CONTROL: begin
				rdata_d[`PE_BIT_LCD_EN] = lcd_en_q;
				rdata_d[`PE_BIT_MUX_HI:`PE_BIT_MUX_LO] = mux_q;
			end
			`PE_OFF_LCD_SEG_EN3: begin
				rdata_d[`PE_BIT_LCD_SEGMENT_31] = lcd_segment_31_q;
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// Read data stand for the one cycle after the strobe.
	// They fall back to zero so a stale value never looks like a fresh one.
	always @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			REG_RDATA_O <= 8'h00;
		end else if (REG_RD_I) begin
			REG_RDATA_O <= rdata_d;
		end else begin
			REG_RDATA_O <= 8'h00;
		end
	end

endmodule // pe_gpio_top

// ### hw/pe_gpio_consts.vh
// Register map, field positions and reset values of the port E block.
`ifndef PE_GPIO_CONSTS_VH
`define PE_GPIO_CONSTS_VH

// Register indices on the plain register port.
`define PE_ADDR_W            3
`define PE_OFF_PIN_LEVELS    3'h0
`define PE_OFF_OUT_LATCH     3'h1
`define PE_OFF_DIRECTION     3'h2
`define PE_OFF_PINS_G_PU     3'h3
`define PE_OFF_DIR_G_OD      3'h4
`define PE_OFF_LCD_CONTROL   3'h5
`define PE_OFF_LCD_SEG_EN3   3'h6

// Data width and implemented pin mask.
`define PE_DATA_W            8
`define PE_IMPL_MASK         8'hFB

// Field positions.
`define PE_BIT_PULLUP_DIS    6
`define PE_BIT_CHAN2_OD      6
`define PE_BIT_LCD_EN        7
`define PE_BIT_MUX_HI        1
`define PE_BIT_MUX_LO        0
`define PE_BIT_LCD_SEGMENT_31         7
`define PE_BIT_CHAN2_PIN     7
`define PE_BIT_COM_BASE      3
`define PE_BIT_BIAS_1        0
`define PE_BIT_BIAS_2        1
`define PE_BIT_UNUSED        2

// Reset values.
`define PE_RST_LATCH         8'h00
`define PE_RST_DIRECTION     8'hFB
`define PE_RST_PULLUP_DIS    1'b1
`define PE_RST_CHAN2_OD      1'b0
`define PE_RST_LCD_EN        1'b0
`define PE_RST_MUX           2'h0
`define PE_RST_LCD_SEGMENT_31         1'b0

`endif

// ### hw/pe_sync2.v
// Two-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/100ps

module pe_sync2 #(
	parameter WIDTH = 1
) (
	// Clock and reset.
	input  wire             clk_i,
	input  wire             rst_n_i,
	// Asynchronous level in, synchronised level out.
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule // pe_sync2

// ### sim/pe_gpio_monitor.sv
// Checker of the port E block's register and pad behaviour.
`timescale 1ns/100ps

module pe_gpio_monitor #(
	parameter NUM_COMMONS = 4
) (
	// Clock, reset and register port.
	input wire       REF_CLK_I,
	input wire       RST_N_I,
	input wire [2:0] REG_ADDR_I,
	input wire [7:0] REG_WDATA_I,
	input wire       REG_WR_I,
	input wire       REG_RD_I,
	input wire [7:0] REG_RDATA_O,
	// Pads and LCD hand-over.
	input wire [7:0] PIN_OE_O,
	input wire [7:0] PULLUP_EN_O,
	input wire [3:0] LCD_COM_SEL_O,
	input wire       LCD_LCD_SEGMENT_31_SEL_O,
	input wire       LCD_BIAS_SEL_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);
	a_latch_echo:
		assert property ((REG_WR_I && REG_ADDR_I == 3'h1) ##1 (REG_RD_I &&
			REG_ADDR_I == 3'h1) |=> REG_RDATA_O == ($past(REG_WDATA_I, 2) & 8'hFB))
		else $error("latch read-back differs from the write.");
	a_unmapped_zero:
		assert property (REG_RD_I && REG_ADDR_I == 3'h7 |=> REG_RDATA_O == 8'h00)
		else $error("unmapped read is not zero.");
	a_bit2_dead:
		assert property (PIN_OE_O[2] == 1'b0 && PULLUP_EN_O[2] == 1'b0)
		else $error("absent pin position is active.");
	a_pullup_output:
		assert property ((PIN_OE_O & PULLUP_EN_O) == 8'h00)
		else $error("pull-up on while driving.");
	a_com_therm:
		assert property (LCD_COM_SEL_O inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
		else $error("common set is not contiguous.");
	a_com_owns:
		assert property (((PIN_OE_O[6:3] | PULLUP_EN_O[6:3]) & LCD_COM_SEL_O) == 4'h0)
		else $error("common pin still used by the port.");
	a_bias_owns:
		assert property (LCD_BIAS_SEL_O |-> (PIN_OE_O[1:0] | PULLUP_EN_O[1:0]) == 2'h0)
		else $error("bias pin still used by the port.");
	a_seg_owns:
		assert property (LCD_LCD_SEGMENT_31_SEL_O |-> !PIN_OE_O[7] && !PULLUP_EN_O[7])
		else $error("segment pin still used by the port.");
	a_reset_quiet:
		assert property ($rose(RST_N_I) |-> (PIN_OE_O == 8'h00 &&
			PULLUP_EN_O == 8'h00)[*2])
		else $error("pads active after reset.");
	c_all_commons: cover property (LCD_COM_SEL_O == 4'hF);
	c_unmapped: cover property (REG_RD_I && REG_ADDR_I == 3'h7);
	c_segment: cover property (LCD_LCD_SEGMENT_31_SEL_O);
endmodule // pe_gpio_monitor

bind pe_gpio_top pe_gpio_monitor #(.NUM_COMMONS(NUM_COMMONS))
	pe_gpio_monitor_inst (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
	.REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
	.REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .PIN_OE_O(PIN_OE_O),
	.PULLUP_EN_O(PULLUP_EN_O), .LCD_COM_SEL_O(LCD_COM_SEL_O),
	.LCD_LCD_SEGMENT_31_SEL_O(LCD_LCD_SEGMENT_31_SEL_O), .LCD_BIAS_SEL_O(LCD_BIAS_SEL_O));

// ### sim/pe_pad_model.sv
// Board-side model of the port E pads.
`timescale 1ns/100ps

module pe_pad_model (
	// Clock and block side.
	input  wire       clk_i,
	input  wire [7:0] pin_out_i,
	input  wire [7:0] pin_oe_i,
	input  wire [7:0] pullup_en_i,
	// Board drivers and resolved level.
	input  wire [7:0] ext_en_i,
	input  wire [7:0] ext_val_i,
	output wire [7:0] pin_level_o
);
	reg flt_q = 1'b0;

	// A pin nobody drives or pulls up wanders every cycle.
	always @(posedge clk_i) begin
		flt_q <= ~flt_q;
	end
	assign pin_level_o = (pin_oe_i & pin_out_i) |
		(~pin_oe_i & ext_en_i & ext_val_i) |
		(~pin_oe_i & ~ext_en_i & (pullup_en_i | {8{flt_q}}));
endmodule // pe_pad_model

// ### sim/testbench.sv
// Self-checking bench for the port E block.
`timescale 1ns/100ps

module testbench;
	reg        clk = 1'b0;
	reg        rst_n = 1'b0;
	reg  [2:0] addr = 3'h0;
	reg  [7:0] wdat = 8'h00;
	reg        wr = 1'b0;
	reg        rd = 1'b0;
	reg        fuse = 1'b1;
	reg        c_act = 1'b0;
	reg        c_out = 1'b0;
	reg  [7:0] x_en = 8'h00;
	reg  [7:0] x_val = 8'h00;
	wire [7:0] rdat;
	wire [7:0] lvl;
	wire [7:0] pout;
	wire [7:0] poe;
	wire [7:0] pu;
	wire [3:0] com;
	wire       capt;
	wire       seg;
	wire       bias;
	integer    errors = 0;
	integer    samples_checked = 0;
	integer    cycles = 0;

	always #2.5 clk = ~clk;
	pe_gpio_top pe_gpio_top_inst (.REF_CLK_I(clk), .RST_N_I(rst_n),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_RDATA_O(rdat), .PIN_IN_I(lvl), .PIN_OUT_O(pout), .PIN_OE_O(poe),
		.PULLUP_EN_O(pu), .CHAN2_PIN_MAP_FUSE_I(fuse),
		.CHAN2_CMP_ACTIVE_I(c_act), .CHAN2_CMP_OUT_I(c_out),
		.CHAN2_CAPTURE_O(capt), .LCD_COM_SEL_O(com),
		.LCD_LCD_SEGMENT_31_SEL_O(seg), .LCD_BIAS_SEL_O(bias));
	pe_pad_model pe_pad_model_inst (.clk_i(clk), .pin_out_i(pout),
		.pin_oe_i(poe), .pullup_en_i(pu), .ext_en_i(x_en),
		.ext_val_i(x_val), .pin_level_o(lvl));

	task chk(input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
			end
		end
	endtask
	// The write strobe stays up until a later read or pin check lowers it.
	task wr_reg(input [2:0] a, input [7:0] d);
		begin
			addr <= a;
			wdat <= d;
			wr <= 1'b1;
			@(posedge clk);
		end
	endtask
	task rd_chk(input [2:0] a, input [7:0] exp);
		begin
			wr <= 1'b0;
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 chk(rdat, exp);
			@(posedge clk);
		end
	endtask
	task pins(input [7:0] oe, input [7:0] out, input [7:0] up);
		begin
			wr <= 1'b0;
			repeat (4) @(posedge clk);
			#1 chk(poe, oe);
			chk(pout, out);
			chk(pu, up);
			@(posedge clk);
		end
	endtask
	task t_regs;
		begin
			rd_chk(3'h2, 8'hFB);
			rd_chk(3'h3, 8'h40);
			wr_reg(3'h1, 8'hFF);
			rd_chk(3'h1, 8'hFB);
			wr_reg(3'h0, 8'h5A);
			rd_chk(3'h1, 8'h5A);
			wr_reg(3'h1, 8'hA9);
			rd_chk(3'h1, 8'hA9);
			wr_reg(3'h7, 8'hFF);
			rd_chk(3'h7, 8'h00);
		end
	endtask
	task t_drive;
		begin
			wr_reg(3'h2, 8'h00);
			pins(8'hFB, 8'hA9, 8'h00);
			wr_reg(3'h3, 8'h00);
			wr_reg(3'h2, 8'hF0);
			pins(8'h0B, 8'hA9, 8'hF0);
			x_en <= 8'hFF;
			x_val <= 8'h96;
			wr_reg(3'h2, 8'hFF);
			pins(8'h00, 8'hA9, 8'hFB);
			rd_chk(3'h0, 8'h92);
			rd_chk(3'h2, 8'hFB);
			wr_reg(3'h3, 8'h40);
			pins(8'h00, 8'hA9, 8'h00);
			x_en <= 8'h00;
			wr_reg(3'h2, 8'h00);
		end
	endtask
	task t_lcd;
		integer   m;
		reg [3:0] c;
		reg [7:0] o;
		begin
			for (m = 0; m < 4; m = m + 1) begin
				c = (4'h1 << (m + 1)) - 4'h1;
				o = {1'b0, c, 3'h0};
				wr_reg(3'h5, 8'h80 | m[7:0]);
				pins(8'hF8 & ~o, 8'hA8 & ~o, 8'h00);
				chk({4'h0, com}, {4'h0, c});
				chk({7'h00, bias}, 8'h01);
				rd_chk(3'h5, 8'h80 | m[7:0]);
			end
			wr_reg(3'h5, 8'h00);
			wr_reg(3'h6, 8'h80);
			rd_chk(3'h6, 8'h80);
			pins(8'h7B, 8'h29, 8'h00);
			chk({7'h00, seg}, 8'h01);
			wr_reg(3'h6, 8'h00);
		end
	endtask
	task t_chan2;
		begin
			wr_reg(3'h1, 8'h29);
			fuse <= 1'b0;
			c_act <= 1'b1;
			c_out <= 1'b1;
			pins(8'hFB, 8'hA9, 8'h00);
			c_out <= 1'b0;
			wr_reg(3'h1, 8'hA9);
			pins(8'hFB, 8'h29, 8'h00);
			wr_reg(3'h4, 8'h40);
			rd_chk(3'h4, 8'h40);
			pins(8'hFB, 8'h29, 8'h00);
			c_out <= 1'b1;
			pins(8'h7B, 8'h29, 8'h00);
			fuse <= 1'b1;
			wr_reg(3'h1, 8'h29);
			pins(8'hFB, 8'h29, 8'h00);
			fuse <= 1'b0;
			x_en <= 8'h80;
			x_val <= 8'h80;
			wr_reg(3'h2, 8'h80);
			pins(8'h7B, 8'h29, 8'h00);
			chk({7'h00, capt}, 8'h01);
			x_val <= 8'h00;
			pins(8'h7B, 8'h29, 8'h00);
			chk({7'h00, capt}, 8'h00);
		end
	endtask
	task end_sim;
		begin
			if (errors == 0 && samples_checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			end_sim;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk(poe, 8'h00);
		chk(pu, 8'h00);
		@(posedge clk);
		t_regs;
		t_drive;
		t_lcd;
		t_chan2;
		end_sim;
	end
endmodule // testbench
